// ---- rtl/revsb_params.svh ----
`ifndef REVSB_PARAMS_SVH
`define REVSB_PARAMS_SVH

// Byte 4 of the event status register
`define REVSB_B4_TX_POWERUP_TIME_ERROR_BIT        2
`define REVSB_B4_RSVD_MSB          7
`define REVSB_B4_RSVD_LSB          3

// Receive event byte, positions of our own choosing
`define REVSB_RXB_SFD_BIT          1
`define REVSB_RXB_PREJ_BIT         0

// Reset values
`define REVSB_BYTE_RESET           8'h00
`define REVSB_CNT_RESET            12'h000

// Widths and counts
`define REVSB_CNT_WIDTH            12
`define REVSB_CONFIRM_SYMBOLS      4'h8
`define REVSB_DEGRADE_SYMBOLS      4'h4
`define REVSB_SYM_CNT_WIDTH        4

`endif

// ---- rtl/revsb_pkg.sv ----
`default_nettype none

package revsb_pkg;

    typedef enum logic [1:0] {
        RX_OFF,
        RX_HUNT,
        RX_CONFIRM,
        RX_LOCKED
    } revsb_rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_WAIT_SEND,
        TX_PREAMBLE,
        TX_FRAME
    } revsb_tx_state_t;

endpackage : revsb_pkg

`default_nettype wire

// ---- rtl/revsb_flag.sv ----
`default_nettype none

module revsb_flag
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Events
    input  wire logic set_evt,
    input  wire logic clear_evt,
    // State
    output logic      flag
);

    // Set wins over clear so an event in the clearing cycle is kept
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            flag <= 1'b0;
        else if (set_evt)
            flag <= 1'b1;
        else if (clear_evt)
            flag <= 1'b0;
    end

endmodule : revsb_flag

`default_nettype wire

// ---- rtl/revsb_sat_counter.sv ----
`include "revsb_params.svh"
`default_nettype none

module revsb_sat_counter
(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    // Control
    input  wire logic                        count_en,
    input  wire logic                        clear,
    input  wire logic                        inc,
    // Value
    output logic [`REVSB_CNT_WIDTH-1:0]      value
);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            value <= `REVSB_CNT_RESET;
        else if (clear)
            value <= `REVSB_CNT_RESET;
        else if (count_en && inc && (value != {`REVSB_CNT_WIDTH{1'b1}}))
            value <= value + 1'b1;
    end

endmodule : revsb_sat_counter

`default_nettype wire

// ---- rtl/revsb_status.sv ----
// How it works
// - The preamble reject flag never reaches the interrupt output, whatever the mask says.
// - Writing a one to the preamble reject bit clears it; writing zero leaves it alone.
// - Every receiver enable, including an automatic re-enable, clears the preamble reject flag.
// - The transmit power-up time error flag reads at bit 2 of status byte 4.
// - The power-up time error is raised only in delayed sends when power-up is late at send time.
// - After a power-up time error the frame still goes out and the ranging marker keeps its time.
// - Only the first few preamble symbols after the error are marked as possibly degraded.
// - Software writes to the power-up time error bit have no effect on it.
// - The power-up time error flag clears when preamble starts or when the transmitter goes idle.
// - Each power-up time error is counted only while event counting is enabled.
// - Bits 7 to 3 of status byte 4 read as zero and ignore writes.
// - A preamble seen but not confirmed sets the reject flag and leaves the SFD flag clear.
`include "revsb_params.svh"
`default_nettype none

module revsb_status
    import revsb_pkg::*;
(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    // Host status access
    input  wire logic                        rxb_wr,
    input  wire logic                        b4_wr,
    input  wire logic [7:0]                  wr_data,
    output logic [7:0]                       rxb_rd_data,
    output logic [7:0]                       b4_rd_data,
    // Interrupt masking
    input  wire logic                        mask_sfd,
    input  wire logic                        mask_prej,
    output logic                             irq,
    // Receiver events
    input  wire logic                        rx_enable,
    input  wire logic                        rx_auto_reenable,
    input  wire logic                        rx_disable,
    input  wire logic                        preamble_seen,
    input  wire logic                        preamble_present,
    input  wire logic                        sfd_seen,
    input  wire logic                        symbol_tick,
    output logic                             preamble_reject_flag,
    output logic                             sfd_detected_flag,
    // Transmitter events
    input  wire logic                        tx_start_now,
    input  wire logic                        tx_start_delayed,
    input  wire logic                        tx_powerup_done,
    input  wire logic                        send_time_reached,
    input  wire logic                        preamble_done,
    input  wire logic                        ranging_marker_due,
    input  wire logic                        tx_frame_done,
    input  wire logic                        force_idle,
    output logic                             tx_active,
    output logic                             tx_preamble_on,
    output logic                             tx_symbol_degraded,
    output logic                             ranging_marker,
    output logic                             tx_powerup_time_error,
    // Event counter
    input  wire logic                        event_count_enable,
    input  wire logic                        event_count_clear,
    output logic [`REVSB_CNT_WIDTH-1:0]      tx_powerup_warn_count
);

    ////////////////////////////////////////////////////////////////////////////////
    // Receive side

    revsb_rx_state_t                     rx_state;
    logic [`REVSB_SYM_CNT_WIDTH-1:0]     confirm_cnt;
    logic                                rx_enable_any;
    logic                                prej_set;
    logic                                prej_clear;
    logic                                sfd_set;
    logic                                sfd_clear;

    assign rx_enable_any = rx_enable || rx_auto_reenable;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rx_state    <= RX_OFF;
            confirm_cnt <= '0;
        end
        else if (rx_disable)
        begin
            rx_state    <= RX_OFF;
            confirm_cnt <= '0;
        end
        else if (rx_enable_any)
        begin
            rx_state    <= RX_HUNT;
            confirm_cnt <= '0;
        end
        else
        begin
            case (rx_state)
                RX_OFF:
                begin
                    confirm_cnt <= '0;
                end
                RX_HUNT:
                begin
                    if (preamble_seen)
                    begin
                        rx_state    <= RX_CONFIRM;
                        confirm_cnt <= '0;
                    end
                end
                RX_CONFIRM:
                begin
                    if (!preamble_present)
                        rx_state <= RX_HUNT;
                    else if (symbol_tick)
                    begin
                        if (confirm_cnt == `REVSB_CONFIRM_SYMBOLS - 1'b1)
                            rx_state <= RX_LOCKED;
                        confirm_cnt <= confirm_cnt + 1'b1;
                    end
                end
                RX_LOCKED:
                begin
                    // Lock holds until the next enable or a disable
                    confirm_cnt <= '0;
                end
                default:
                begin
                    rx_state    <= RX_OFF;
                    confirm_cnt <= '0;
                end
            endcase
        end
    end

    // Losing the preamble during confirmation is the reject event
    assign prej_set   = (rx_state == RX_CONFIRM) && !preamble_present
                        && !rx_enable_any && !rx_disable;
    assign prej_clear = (rxb_wr && wr_data[`REVSB_RXB_PREJ_BIT])
                        || rx_enable_any;

    // SFD can only be flagged once the preamble was confirmed
    assign sfd_set   = (rx_state == RX_LOCKED) && sfd_seen && !rx_enable_any;
    assign sfd_clear = (rxb_wr && wr_data[`REVSB_RXB_SFD_BIT]) || rx_enable_any;

    revsb_flag u_prej_flag
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .set_evt   (prej_set),
        .clear_evt (prej_clear),
        .flag      (preamble_reject_flag)
    );

    revsb_flag u_sfd_flag
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .set_evt   (sfd_set),
        .clear_evt (sfd_clear),
        .flag      (sfd_detected_flag)
    );

    // The reject mask is accepted but has no path to the interrupt
    logic unused_mask_prej;
    assign unused_mask_prej = mask_prej;
    assign irq = sfd_detected_flag && mask_sfd;

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit side

    revsb_tx_state_t                     tx_state;
    logic                                delayed_mode;
    logic                                pute_set;
    logic                                pute_clear;
    logic                                preamble_start;
    logic [`REVSB_SYM_CNT_WIDTH-1:0]     degrade_cnt;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tx_state     <= TX_IDLE;
            delayed_mode <= 1'b0;
        end
        else if (force_idle)
        begin
            tx_state     <= TX_IDLE;
            delayed_mode <= 1'b0;
        end
        else
        begin
            case (tx_state)
                TX_IDLE:
                begin
                    if (tx_start_delayed)
                    begin
                        tx_state     <= TX_WAIT_SEND;
                        delayed_mode <= 1'b1;
                    end
                    else if (tx_start_now)
                    begin
                        tx_state     <= TX_PREAMBLE;
                        delayed_mode <= 1'b0;
                    end
                end
                TX_WAIT_SEND:
                begin
                    // Send goes ahead at the scheduled time even if power-up is late
                    if (send_time_reached)
                        tx_state <= TX_PREAMBLE;
                end
                TX_PREAMBLE:
                begin
                    if (preamble_done)
                        tx_state <= TX_FRAME;
                end
                TX_FRAME:
                begin
                    if (tx_frame_done)
                    begin
                        tx_state     <= TX_IDLE;
                        delayed_mode <= 1'b0;
                    end
                end
                default:
                begin
                    tx_state     <= TX_IDLE;
                    delayed_mode <= 1'b0;
                end
            endcase
        end
    end

    assign pute_set = (tx_state == TX_WAIT_SEND) && delayed_mode
                      && send_time_reached && !tx_powerup_done && !force_idle;

    // Preamble begins in the cycle after the send time, so set and clear never coincide
    assign preamble_start = (tx_state == TX_WAIT_SEND) && send_time_reached
                            || (tx_state == TX_IDLE) && tx_start_now && !tx_start_delayed;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tx_preamble_on <= 1'b0;
        else if (force_idle)
            tx_preamble_on <= 1'b0;
        else if (preamble_start)
            tx_preamble_on <= 1'b1;
        else if (tx_state == TX_PREAMBLE && preamble_done)
            tx_preamble_on <= 1'b0;
    end

    // Software write strobes for byte 4 are deliberately not wired here
    logic       unused_b4_wr;
    assign unused_b4_wr = b4_wr;
    assign pute_clear   = (tx_state == TX_PREAMBLE) && tx_preamble_on
                          || force_idle;

    revsb_flag u_pute_flag
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .set_evt   (pute_set),
        .clear_evt (pute_clear),
        .flag      (tx_powerup_time_error)
    );

    // Only the leading preamble symbols are flagged; the rest of the frame is clean
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            degrade_cnt <= '0;
        else if (force_idle)
            degrade_cnt <= '0;
        else if (pute_set)
            degrade_cnt <= `REVSB_DEGRADE_SYMBOLS;
        else if (symbol_tick && degrade_cnt != '0 && tx_state == TX_PREAMBLE)
            degrade_cnt <= degrade_cnt - 1'b1;
        else if (tx_state != TX_PREAMBLE && tx_state != TX_WAIT_SEND)
            degrade_cnt <= '0;
    end

    assign tx_symbol_degraded = (degrade_cnt != '0) && (tx_state == TX_PREAMBLE);

    // Marker timing is independent of the power-up error
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ranging_marker <= 1'b0;
        else
            ranging_marker <= ranging_marker_due
                              && (tx_state == TX_PREAMBLE || tx_state == TX_FRAME);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tx_active <= 1'b0;
        else
            tx_active <= (tx_state == TX_PREAMBLE) || (tx_state == TX_FRAME);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event counter

    // One set pulse per failing send, so the count moves by one each time counting is enabled and not full
    revsb_sat_counter u_warn_cnt
    (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .count_en (event_count_enable),
        .clear    (event_count_clear),
        .inc      (pute_set),
        .value    (tx_powerup_warn_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read back

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rxb_rd_data <= `REVSB_BYTE_RESET;
            b4_rd_data  <= `REVSB_BYTE_RESET;
        end
        else
        begin
            rxb_rd_data                      <= `REVSB_BYTE_RESET;
            rxb_rd_data[`REVSB_RXB_SFD_BIT]  <= sfd_detected_flag;
            rxb_rd_data[`REVSB_RXB_PREJ_BIT] <= preamble_reject_flag;
            b4_rd_data                       <= `REVSB_BYTE_RESET;
            b4_rd_data[`REVSB_B4_TX_POWERUP_TIME_ERROR_BIT] <= tx_powerup_time_error;
        end
    end

endmodule : revsb_status

`default_nettype wire

// ---- sim/revsb_status_asserts.sv ----
`include "revsb_params.svh"
`default_nettype none

module revsb_status_asserts
(
    // Clock and reset
    input wire logic                        ref_clk,
    input wire logic                        reset,
    // Host and receiver side
    input wire logic                        rxb_wr,
    input wire logic [7:0]                  wr_data,
    input wire logic                        mask_sfd,
    input wire logic                        irq,
    input wire logic                        rx_enable,
    input wire logic                        rx_auto_reenable,
    input wire logic                        preamble_present,
    input wire logic                        preamble_reject_flag,
    input wire logic                        sfd_detected_flag,
    input wire logic [7:0]                  b4_rd_data,
    // Transmitter and counter side
    input wire logic                        send_time_reached,
    input wire logic                        tx_powerup_done,
    input wire logic                        tx_powerup_time_error,
    input wire logic                        ranging_marker_due,
    input wire logic                        ranging_marker,
    input wire logic                        event_count_enable,
    input wire logic                        event_count_clear,
    input wire logic [`REVSB_CNT_WIDTH-1:0] tx_powerup_warn_count
);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////////
    // Receive flags

    a_irq_no_prej: assert property (
        irq == (sfd_detected_flag && mask_sfd))
        else $error("irq does not follow the masked sfd flag");
    a_prej_one_clears: assert property (
        rxb_wr && wr_data[0] && preamble_present |=> !preamble_reject_flag)
        else $error("writing one left the reject flag set");
    a_prej_zero_keeps: assert property (
        rxb_wr && !wr_data[0] && preamble_reject_flag && !rx_enable && !rx_auto_reenable
        |=> preamble_reject_flag)
        else $error("writing zero cleared the reject flag");
    a_prej_rx_enable: assert property (
        rx_enable || rx_auto_reenable |=> !preamble_reject_flag)
        else $error("receiver enable left the reject flag set");
    a_prej_set_cause: assert property (
        $rose(preamble_reject_flag) |-> !$past(preamble_present))
        else $error("reject flag set while preamble continued");

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit error flag, ranging marker and counter

    a_b4_layout: assert property (
        b4_rd_data == {5'h00, $past(tx_powerup_time_error), 2'h0})
        else $error("status byte 4 read value wrong");
    a_pute_late_only: assert property (
        $rose(tx_powerup_time_error) |-> $past(send_time_reached) && !$past(tx_powerup_done))
        else $error("error flag raised without a late power-up");
    a_pute_self_clear: assert property (
        $rose(tx_powerup_time_error) |=> !tx_powerup_time_error)
        else $error("error flag did not clear at preamble start");
    a_ranging_marker_timing: assert property (
        $rose(ranging_marker) |-> $past(ranging_marker_due))
        else $error("ranging marker without its due pulse");
    a_count_step: assert property (
        $rose(tx_powerup_time_error) && !$past(event_count_clear)
        && $past(tx_powerup_warn_count) != 12'hFFF
        |-> tx_powerup_warn_count == $past(tx_powerup_warn_count)
            + {11'h000, $past(event_count_enable)})
        else $error("warning counter step wrong");
    a_count_hold: assert property (
        !$rose(tx_powerup_time_error) && !$past(event_count_clear)
        |-> $stable(tx_powerup_warn_count))
        else $error("warning counter moved without an error");

endmodule : revsb_status_asserts

bind revsb_status revsb_status_asserts u_revsb_status_asserts
(
    .ref_clk(ref_clk), .reset(reset), .rxb_wr(rxb_wr), .wr_data(wr_data),
    .mask_sfd(mask_sfd), .irq(irq), .rx_enable(rx_enable),
    .rx_auto_reenable(rx_auto_reenable), .preamble_present(preamble_present),
    .preamble_reject_flag(preamble_reject_flag), .sfd_detected_flag(sfd_detected_flag),
    .b4_rd_data(b4_rd_data), .send_time_reached(send_time_reached),
    .tx_powerup_done(tx_powerup_done), .tx_powerup_time_error(tx_powerup_time_error),
    .ranging_marker_due(ranging_marker_due), .ranging_marker(ranging_marker),
    .event_count_enable(event_count_enable), .event_count_clear(event_count_clear),
    .tx_powerup_warn_count(tx_powerup_warn_count)
);

`default_nettype wire

// ---- sim/testbench.sv ----
`include "revsb_params.svh"
`default_nettype none

module testbench
    import revsb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk, reset, rxb_wr, b4_wr, mask_sfd, mask_prej, rx_enable, rx_auto_reenable;
    logic rx_disable, preamble_seen, preamble_present, sfd_seen, symbol_tick, tx_start_now;
    logic tx_start_delayed, tx_powerup_done, send_time_reached, preamble_done, ranging_marker_due;
    logic tx_frame_done, force_idle, event_count_enable, event_count_clear;
    logic irq, preamble_reject_flag, sfd_detected_flag, tx_active, tx_preamble_on;
    logic tx_symbol_degraded, ranging_marker, tx_powerup_time_error;
    logic [7:0]                  wr_data;
    logic [7:0]                  rxb_rd_data;
    logic [7:0]                  b4_rd_data;
    logic [`REVSB_CNT_WIDTH-1:0] tx_powerup_warn_count;
    int                          mismatches;
    int                          num_checks;

    revsb_status u_revsb_status
    (
        .ref_clk(ref_clk), .reset(reset), .rxb_wr(rxb_wr), .b4_wr(b4_wr), .wr_data(wr_data),
        .rxb_rd_data(rxb_rd_data), .b4_rd_data(b4_rd_data), .mask_sfd(mask_sfd),
        .mask_prej(mask_prej), .irq(irq), .rx_enable(rx_enable),
        .rx_auto_reenable(rx_auto_reenable), .rx_disable(rx_disable),
        .preamble_seen(preamble_seen), .preamble_present(preamble_present),
        .sfd_seen(sfd_seen), .symbol_tick(symbol_tick),
        .preamble_reject_flag(preamble_reject_flag), .sfd_detected_flag(sfd_detected_flag),
        .tx_start_now(tx_start_now), .tx_start_delayed(tx_start_delayed),
        .tx_powerup_done(tx_powerup_done), .send_time_reached(send_time_reached),
        .preamble_done(preamble_done), .ranging_marker_due(ranging_marker_due),
        .tx_frame_done(tx_frame_done), .force_idle(force_idle), .tx_active(tx_active),
        .tx_preamble_on(tx_preamble_on), .tx_symbol_degraded(tx_symbol_degraded),
        .ranging_marker(ranging_marker), .tx_powerup_time_error(tx_powerup_time_error),
        .event_count_enable(event_count_enable), .event_count_clear(event_count_clear),
        .tx_powerup_warn_count(tx_powerup_warn_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks

    // Inputs always move 5 ns after the edge, so no race with the design's flops
    task automatic tick();
        @(posedge ref_clk);
        #5;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic host_write(input logic [7:0] data);
        rxb_wr = 1'b1;
        wr_data = data;
        tick();
        rxb_wr = 1'b0;
    endtask : host_write

    // Enable, see a preamble, then lose it during confirmation
    task automatic reject();
        rx_enable = 1'b1;
        tick();
        rx_enable = 1'b0;
        preamble_seen = 1'b1;
        tick();
        preamble_seen = 1'b0;
        preamble_present = 1'b0;
        tick();
    endtask : reject

    task automatic delayed_send(input logic late);
        tx_start_delayed = 1'b1;
        tick();
        tx_start_delayed = 1'b0;
        send_time_reached = 1'b1;
        tx_powerup_done = !late;
        tick();
        send_time_reached = 1'b0;
    endtask : delayed_send

    task automatic end_tx();
        force_idle = 1'b1;
        tick();
        force_idle = 1'b0;
    endtask : end_tx

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and sequence

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        {rxb_wr, b4_wr, mask_sfd, mask_prej, rx_enable, rx_auto_reenable, rx_disable} = '0;
        {preamble_seen, preamble_present, sfd_seen, symbol_tick, tx_start_now} = '0;
        {tx_start_delayed, tx_powerup_done, send_time_reached, preamble_done} = '0;
        {ranging_marker_due, tx_frame_done, force_idle, event_count_enable, event_count_clear} = '0;
        wr_data = 8'h00;
        mismatches = 0;
        num_checks = 0;
        reset = 1'b1;
        repeat (5) tick();
        reset = 1'b0;
        check(b4_rd_data, 8'h00);
        check(tx_powerup_warn_count, 12'h000);
        mask_sfd = 1'b1;
        mask_prej = 1'b1;
        reject();
        check(preamble_reject_flag, 1'b1);
        check(sfd_detected_flag, 1'b0);
        check(irq, 1'b0);
        tick();
        check(rxb_rd_data, 8'h01);
        host_write(8'hFE);
        check(preamble_reject_flag, 1'b1);
        preamble_present = 1'b1;
        host_write(8'h01);
        check(preamble_reject_flag, 1'b0);
        reject();
        check(preamble_reject_flag, 1'b1);
        rx_auto_reenable = 1'b1;
        tick();
        rx_auto_reenable = 1'b0;
        check(preamble_reject_flag, 1'b0);
        reject();
        rx_enable = 1'b1;
        tick();
        rx_enable = 1'b0;
        check(preamble_reject_flag, 1'b0);
        // A confirmed preamble reaches lock, so only the SFD flag may rise
        preamble_present = 1'b1;
        preamble_seen = 1'b1;
        tick();
        preamble_seen = 1'b0;
        symbol_tick = 1'b1;
        repeat (8) tick();
        symbol_tick = 1'b0;
        sfd_seen = 1'b1;
        tick();
        sfd_seen = 1'b0;
        check({preamble_reject_flag, sfd_detected_flag, irq}, 3'h3);
        mask_sfd = 1'b0;
        host_write(8'h02);
        check({sfd_detected_flag, irq}, 2'h0);
        b4_wr = 1'b1;
        wr_data = 8'hFF;
        tick();
        b4_wr = 1'b0;
        tick();
        check({tx_powerup_time_error, b4_rd_data}, 9'h000);
        event_count_enable = 1'b1;
        delayed_send(1'b1);
        check(tx_powerup_time_error, 1'b1);
        check(tx_powerup_warn_count, 12'h001);
        tick();
        check(tx_powerup_time_error, 1'b0);
        check(b4_rd_data, 8'h04);
        check(tx_active, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            check(tx_symbol_degraded, 1'b1);
            symbol_tick = 1'b1;
            tick();
            symbol_tick = 1'b0;
        end
        check(tx_symbol_degraded, 1'b0);
        ranging_marker_due = 1'b1;
        tick();
        ranging_marker_due = 1'b0;
        check(ranging_marker, 1'b1);
        preamble_done = 1'b1;
        tick();
        preamble_done = 1'b0;
        tx_frame_done = 1'b1;
        tick();
        tx_frame_done = 1'b0;
        tick();
        check({tx_active, tx_preamble_on}, 2'h0);
        delayed_send(1'b0);
        check(tx_powerup_time_error, 1'b0);
        end_tx();
        tx_start_now = 1'b1;
        tick();
        tx_start_now = 1'b0;
        delayed_send(1'b1);
        check(tx_powerup_warn_count, 12'h001);
        end_tx();
        event_count_enable = 1'b0;
        delayed_send(1'b1);
        check(tx_powerup_warn_count, 12'h001);
        end_tx();
        event_count_clear = 1'b1;
        tick();
        event_count_clear = 1'b0;
        check(tx_powerup_warn_count, 12'h000);
        // Run past full scale to prove the counter sticks rather than wraps
        event_count_enable = 1'b1;
        repeat (4100)
        begin
            delayed_send(1'b1);
            end_tx();
        end
        check(tx_powerup_warn_count, 12'hFFF);
        report_and_stop();
    end

endmodule : testbench

`default_nettype wire
